/* File: logic/package_power_limit_regs.sv */
// Register bank and windowed-average enforcement for the package power domain
`timescale 1ns/1ps
`include "power_limit_cfg.svh"

module package_power_limit_regs
	import power_limit_pkg::*;
#(
	parameter logic [24:0] REFRESH_CYCLES = 25'(`REFRESH_CYCLES),
	parameter logic [14:0] DESIGN_POWER = 15'h0100,
	parameter logic [14:0] MIN_POWER = 15'h0040,
	parameter logic [14:0] MAX_POWER = 15'h0200,
	parameter logic [5:0] MAX_WINDOW = 6'h20
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire reg_req_t req,
	input wire logic [15:0] energy_sample,
	input wire logic [14:0] power_sample,
	input wire logic below_requested,
	output logic [63:0] rdata,
	output logic rvalid,
	output limit_status_t status
);
	package_power_limit_t limit, next_limit;
	logic [31:0] energy_total, next_energy_total;
	logic [31:0] energy_pending, next_energy_pending;
	logic [31:0] throttle_time, next_throttle_time;
	logic [24:0] refresh_count, next_refresh_count;
	logic [63:0] next_rdata;
	logic next_rvalid;
	limit_status_t next_status;
	logic [24:0] tick_count, next_tick_count;
	logic [39:0] avg1, next_avg1;
	logic [39:0] avg2, next_avg2;
	logic refresh_tick;
	logic time_tick;
	unit_scaling_t units;
	package_power_range_t range;
	logic [4:0] shift1, shift2;
	logic [24:0] time_unit_cycles;
	logic [6:0] window2_fixed;

	always_comb begin
		units = '0;
		units.power_unit_exponent = `PWR_EXP_DEFAULT;
		units.energy_unit_exponent = `ENERGY_EXP_DEFAULT;
		units.time_unit_exponent = `TIME_EXP_DEFAULT;
		range = '0;
		range.design_power = DESIGN_POWER;
		range.min_power = MIN_POWER;
		range.max_power = MAX_POWER;
		range.max_window = MAX_WINDOW;
	end

	// One time unit is one refresh period (1 ms), though the unit register reports 1/2^10 s
	assign time_unit_cycles = REFRESH_CYCLES;
	// Second window is set from window2_fixed on each limit write and is 0 from reset; software writes to it are dropped
	assign window2_fixed = `WINDOW2_FIXED;
	assign refresh_tick = (refresh_count == REFRESH_CYCLES - 25'h1);
	assign time_tick = (tick_count == time_unit_cycles - 25'h1);

	// Register writes and the lock
	always_comb begin
		next_limit = limit;
		if (req.write && !req.unit_sel && req.offset == `OFS_LIMIT && !limit.lock) begin
			next_limit = package_power_limit_t'(req.wdata);
			next_limit.reserved_lo = '0;
			next_limit.reserved_hi = '0;
			next_limit.window2_frac = window2_fixed[6:5];
			next_limit.window2_exp = window2_fixed[4:0];
		end
	end

	// Read mux; unit register ignores writes
	always_comb begin
		next_rdata = 64'h0;
		next_rvalid = req.read;
		if (req.read) begin
			if (req.unit_sel) begin
				next_rdata = 64'(units);
			end else begin
				unique case (req.offset)
					`OFS_LIMIT: next_rdata = 64'(limit);
					`OFS_ENERGY: next_rdata = {32'h0, energy_total};
					`OFS_THROTTLE: next_rdata = {32'h0, throttle_time};
					`OFS_RANGE: next_rdata = 64'(range);
					default: next_rdata = 64'h0;
				endcase
			end
		end
	end

	// Energy accumulates each cycle, published once per refresh period
	always_comb begin
		next_refresh_count = refresh_tick ? 25'h0 : refresh_count + 25'h1;
		next_energy_pending = energy_pending + {16'h0, energy_sample};
		next_energy_total = energy_total;
		if (refresh_tick) begin
			next_energy_total = energy_total + next_energy_pending;
			next_energy_pending = 32'h0;
		end
	end

	// Windowed averages: exponential filter whose time constant is 2^Y time units
	always_comb begin
		next_tick_count = time_tick ? 25'h0 : tick_count + 25'h1;
		shift1 = limit.window1_exp;
		shift2 = limit.window2_exp;
		next_avg1 = avg1;
		next_avg2 = avg2;
		if (time_tick) begin
			next_avg1 = avg1 - (avg1 >> shift1) + ({25'h0, power_sample} >> shift1);
			next_avg2 = avg2 - (avg2 >> shift2) + ({25'h0, power_sample} >> shift2);
		end
		next_status.limit1_active = limit.enable1 && (avg1[14:0] > limit.limit1);
		next_status.limit2_active = limit.enable2 && (avg2[14:0] > limit.limit2);
		next_status.clamp1_active = next_status.limit1_active && limit.clamp1;
		next_status.clamp2_active = next_status.limit2_active && limit.clamp2;
		next_throttle_time = throttle_time;
		if (time_tick && below_requested && (status.limit1_active || status.limit2_active)) begin
			next_throttle_time = throttle_time + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			limit <= `LIMIT_RESET;
			energy_total <= 32'h0;
			energy_pending <= 32'h0;
			throttle_time <= 32'h0;
			refresh_count <= 25'h0;
			tick_count <= 25'h0;
			avg1 <= 40'h0;
			avg2 <= 40'h0;
			rdata <= 64'h0;
			rvalid <= 1'b0;
			status <= '0;
		end else begin
			limit <= next_limit;
			energy_total <= next_energy_total;
			energy_pending <= next_energy_pending;
			throttle_time <= next_throttle_time;
			refresh_count <= next_refresh_count;
			tick_count <= next_tick_count;
			avg1 <= next_avg1;
			avg2 <= next_avg2;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
			status <= next_status;
		end
	end
endmodule : package_power_limit_regs

/* File: logic/power_limit_cfg.svh */
// Register offsets, unit exponents, reset values and timing counts for the power limit block
`ifndef POWER_LIMIT_CFG_SVH
`define POWER_LIMIT_CFG_SVH

`define OFS_LIMIT 3'h0
`define OFS_ENERGY 3'h1
`define OFS_POLICY 3'h2
`define OFS_THROTTLE 3'h3
`define OFS_RANGE 3'h4

`define PWR_EXP_DEFAULT 4'h3
`define ENERGY_EXP_DEFAULT 5'h10
`define TIME_EXP_DEFAULT 4'ha

`define LIMIT_RESET 64'h0
`define WINDOW2_FIXED 7'h0a

`define CLK_HZ 25000000
`define REFRESH_MS 1
`define REFRESH_CYCLES (`CLK_HZ / 1000 * `REFRESH_MS)

`endif

/* File: logic/power_limit_pkg.sv */
// Types for the package power limit register block
package power_limit_pkg;
	typedef struct packed {
		logic [31:0] reserved_hi;
		logic [11:0] reserved_mid2;
		logic [3:0] time_unit_exponent;
		logic [2:0] reserved_mid;
		logic [4:0] energy_unit_exponent;
		logic [3:0] reserved_lo;
		logic [3:0] power_unit_exponent;
	} unit_scaling_t;

	typedef struct packed {
		logic lock;
		logic [6:0] reserved_hi;
		logic [1:0] window2_frac;
		logic [4:0] window2_exp;
		logic clamp2;
		logic enable2;
		logic [14:0] limit2;
		logic [7:0] reserved_lo;
		logic [1:0] window1_frac;
		logic [4:0] window1_exp;
		logic clamp1;
		logic enable1;
		logic [14:0] limit1;
	} package_power_limit_t;

	typedef struct packed {
		logic [9:0] reserved_hi;
		logic [5:0] max_window;
		logic reserved_b47;
		logic [14:0] max_power;
		logic reserved_b31;
		logic [14:0] min_power;
		logic reserved_b15;
		logic [14:0] design_power;
	} package_power_range_t;

	typedef struct packed {
		logic read;
		logic write;
		logic unit_sel;
		logic [2:0] offset;
		logic [63:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic limit1_active;
		logic clamp1_active;
		logic limit2_active;
		logic clamp2_active;
	} limit_status_t;
endpackage : power_limit_pkg

/* File: verification/power_limit_chk.sv */
// Port-level checks on the package power limit register block
`timescale 1ns/1ps
module power_limit_chk
	import power_limit_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire reg_req_t req,
	input wire logic [63:0] rdata,
	input wire logic rvalid,
	input wire limit_status_t status
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence rd_at(logic [2:0] o);
		req.read && !req.unit_sel && req.offset == o;
	endsequence
	read_answer_a: assert property (req.read |=> rvalid) else $error("read unanswered");
	no_spurious_a: assert property (!req.read |=> !rvalid) else $error("stray rvalid");
	idle_data_a: assert property (!rvalid |-> rdata == 64'h0) else $error("rdata not idle");
	unit_value_a: assert property (req.read && req.unit_sel |=> rdata == 64'ha1003)
		else $error("unit register wrong");
	policy_zero_a: assert property (rd_at(3'h2) |=> rdata == 64'h0) else $error("policy not zero");
	range_value_a: assert property (rd_at(3'h4) |=> rdata == 64'h0020020000400100)
		else $error("range register wrong");
	limit_fixed_a: assert property (rd_at(3'h0) |=> rdata[62:49] == 14'h0a && rdata[31:24] == 8'h0)
		else $error("limit fixed bits wrong");
	status_reset_a: assert property ($fell(sys_rst) |-> status == 4'h0) else $error("status after reset");
endmodule : power_limit_chk
bind package_power_limit_regs power_limit_chk i_chk (.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
	.rvalid(rvalid), .status(status));

/* File: verification/testbench.sv */
// Scenario bench for the package power limit register block
`timescale 1ns/1ps
module testbench import power_limit_pkg::*;;
	logic clk = 0;
	logic sys_rst = 1;
	reg_req_t req = '0;
	logic [15:0] energy_sample = 16'h0010;
	logic [14:0] power_sample = 15'h7fff;
	logic below_requested = 0;
	logic [63:0] rdata, d, e;
	logic rvalid;
	limit_status_t status;
	int num_errors = 0;
	int checks_done = 0;
	always #20 clk = ~clk;
	package_power_limit_regs #(.REFRESH_CYCLES(25'h8)) i_dut (.clk(clk), .sys_rst(sys_rst), .req(req),
		.energy_sample(energy_sample), .power_sample(power_sample), .below_requested(below_requested),
		.rdata(rdata), .rvalid(rvalid), .status(status));
	task conclude;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			num_errors++;
		end
	endtask : chk
	task rd(input logic u, input logic [2:0] o);
		@(posedge clk) req <= '{1'b1, 1'b0, u, o, 64'h0};
		@(posedge clk) req.read <= 1'b0;
		#1;
		if (rvalid !== 1'b1) begin
			num_errors++;
			conclude();
		end
		d = rdata;
	endtask : rd
	task wr(input logic u, input logic [2:0] o, input logic [63:0] w);
		@(posedge clk) req <= '{1'b0, 1'b1, u, o, w};
		@(posedge clk) req.write <= 1'b0;
	endtask : wr
	task t_units;
		rd(1'b1, 3'h0);
		chk(d, 64'ha1003);
		wr(1'b1, 3'h0, '1);
		rd(1'b1, 3'h0);
		chk(d, 64'ha1003);
	endtask : t_units
	task t_fields;
		wr(1'b0, 3'h0, 64'h7fffffffffffffff);
		rd(1'b0, 3'h0);
		chk(d, 64'h0015ffff00ffffff);
		rd(1'b0, 3'h2);
		chk(d, 64'h0);
		rd(1'b0, 3'h3);
		chk(d, 64'h0);
		rd(1'b0, 3'h4);
		chk(d, 64'h0020020000400100);
	endtask : t_fields
	task t_lock;
		wr(1'b0, 3'h0, 64'h8000000000001234);
		wr(1'b0, 3'h0, 64'h0);
		rd(1'b0, 3'h0);
		chk(d, 64'h8014000000001234);
		chk({60'h0, status}, 64'h0);
		@(posedge clk) sys_rst <= 1'b1;
		@(posedge clk) sys_rst <= 1'b0;
		wr(1'b0, 3'h0, 64'h5);
		rd(1'b0, 3'h0);
		chk(d, 64'h0014000000000005);
	endtask : t_lock
	task t_energy;
		wr(1'b0, 3'h1, '1);
		rd(1'b0, 3'h1);
		e = d;
		repeat (6) @(posedge clk);
		rd(1'b0, 3'h1);
		chk(d - e, 64'h80);
	endtask : t_energy
	task t_limits;
		below_requested <= 1'b1;
		wr(1'b0, 3'h0, 64'h0000000000018001);
		repeat (24) @(posedge clk);
		chk({60'h0, status}, 64'hc);
		repeat (24) @(posedge clk);
		rd(1'b0, 3'h3);
		chk({63'h0, d != 64'h0}, 64'h1);
		wr(1'b0, 3'h0, 64'h0000000000000001);
		repeat (24) @(posedge clk);
		chk({60'h0, status}, 64'h0);
		below_requested <= 1'b0;
	endtask : t_limits
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t_units();
		t_fields();
		t_lock();
		t_energy();
		t_limits();
		conclude();
	end
endmodule : testbench
